// ### cdec_pkg.sv
// package: opcodes, field positions, widths and reset values for the decoder
package cdec_pkg;
    localparam int PC_W = 15;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 4;
    localparam int PTR_W = 16;
    localparam int NUM_DIR = 8;
    localparam logic [13:0] OP_IDLE = 14'h0000;
    localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
    localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
    localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
    localparam logic [13:0] OP_CALL_ACC = 14'h000A;
    localparam logic [13:0] OP_JREL_ACC = 14'h000B;
    localparam logic [13:0] OP_LOAD_PRESC = 14'h0062;
    localparam logic [13:0] OP_SLEEP = 14'h0063;
    localparam logic [13:0] OP_WDT_CLEAR = 14'h0064;
    localparam logic [13:0] MASK_DIR = 14'h3FF8;
    localparam logic [13:0] PAT_DIR = 14'h0060;
    localparam logic [13:0] MASK_LDI = 14'h3FF8;
    localparam logic [13:0] PAT_LDI = 14'h0010;
    localparam logic [13:0] PAT_STI = 14'h0018;
    localparam logic [13:0] MASK_K9 = 14'h3E00;
    localparam logic [13:0] PAT_JREL = 14'h3200;
    localparam logic [13:0] MASK_K11 = 14'h3800;
    localparam logic [13:0] PAT_CALL = 14'h2000;
    localparam logic [13:0] PAT_JABS = 14'h2800;
    localparam logic [13:0] MASK_K8 = 14'h3F00;
    localparam logic [13:0] PAT_RETLIT = 14'h3400;
    localparam logic [13:0] MASK_K6 = 14'h3F80;
    localparam logic [13:0] PAT_PADD = 14'h3100;
    localparam logic [13:0] PAT_LDX = 14'h3F00;
    localparam logic [13:0] PAT_STX = 14'h3F80;
    localparam int N_SEL_BIT = 6;
    localparam int N_MM_BIT = 2;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 4'hF;
    localparam logic [7:0] PRESC_RESET = 8'hFF;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
    typedef enum logic [1:0] {
        CDEC_MM_PREINC,
        CDEC_MM_PREDEC,
        CDEC_MM_POSTINC,
        CDEC_MM_POSTDEC
    } cdec_mm_t;
endpackage

// ### cdec_stack_if.sv
// interface: hardware return-address stack push/pop signals
`timescale 1ns/10ps
`default_nettype none
interface cdec_stack_if;
    import cdec_pkg::*;
    logic push;
    logic pop;
    logic [PC_W-1:0] push_data;
    logic [PC_W-1:0] top;
    modport core (output push, output pop, output push_data, input top);
    modport stack (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

// ### cdec_stack.sv
// circular hardware return-address stack
`timescale 1ns/10ps
`default_nettype none
module cdec_stack (
    input wire logic i_clk,
    input wire logic i_rstn,
    cdec_stack_if.stack s
);
    import cdec_pkg::*;
    typedef struct packed {
        logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
        logic [SP_W-1:0] sp;
    } cdec_stk_state_t;
    cdec_stk_state_t st_reg;
    cdec_stk_state_t st_next;
    always_comb begin
        st_next = st_reg;
        if (s.push) begin
            st_next.sp = st_reg.sp + 4'h1;
            st_next.mem[st_reg.sp + 4'h1] = s.push_data;
        end else if (s.pop) begin
            st_next.sp = st_reg.sp - 4'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= '{mem: '0, sp: SP_RESET};
        end else begin
            st_reg <= st_next;
        end
    end
    // overflow wraps silently; no overflow or underflow flag is kept
    assign s.top = st_reg.mem[st_reg.sp];
endmodule // cdec_stack
`default_nettype wire

// ### cdec_core.sv
// top: control, inherent and indirect-move instruction decoder and executor
`timescale 1ns/10ps
`default_nettype none
module cdec_core (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_ext_wr_en,
    input wire logic [7:0] i_ext_wdata,
    input wire logic i_wake,
    output logic [cdec_pkg::PC_W-1:0] o_program_counter,
    output logic o_fetch_stall,
    output logic [7:0] o_accumulator,
    output logic o_result_null_flag,
    output logic o_global_irq_enable,
    output logic o_watchdog_expiry_flag,
    output logic o_powerdown_flag,
    output logic o_soft_reset_flag_n,
    output logic o_device_reset,
    output logic o_watchdog_restart,
    output logic o_sleep,
    output logic [7:0] o_prescaler_config,
    output logic [cdec_pkg::NUM_DIR*8-1:0] o_direction,
    output logic [cdec_pkg::PTR_W-1:0] o_pointer0,
    output logic [cdec_pkg::PTR_W-1:0] o_pointer1,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [cdec_pkg::PTR_W-1:0] o_mem_addr,
    output logic [7:0] o_mem_wdata
);
    import cdec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CDEC_EXEC,
        CDEC_FLUSH,
        CDEC_EXTRA,
        CDEC_LDWAIT
    } cdec_phase_t;

    typedef struct packed {
        cdec_phase_t phase;
        logic [PC_W-1:0] pc;
        logic [7:0] acc;
        logic zflag;
        logic global_irq_enable;
        logic to_flag;
        logic pd_flag;
        logic ri_n;
        logic dev_reset;
        logic wdt_restart;
        logic sleep;
        logic [7:0] presc;
        logic [NUM_DIR-1:0][7:0] dir;
        logic [1:0][PTR_W-1:0] ptr;
        logic mem_rd;
        logic mem_wr;
        logic [PTR_W-1:0] mem_addr;
        logic [7:0] mem_wdata;
        logic ld_pending;
        logic [2:0] wake_sync;
        logic stall;
    } cdec_state_t;

    cdec_state_t st_reg;
    cdec_state_t st_next;

    cdec_stack_if stk ();

    cdec_stack u_stack (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .s(stk.stack)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic op_match(input logic [13:0] w, input logic [13:0] m,
                                      input logic [13:0] p);
        op_match = ((w & m) == p);
    endfunction

    // pointer value after an mm-style modifier; returns the access address
    function automatic logic [2*PTR_W-1:0] mm_apply(input logic [PTR_W-1:0] p,
                                                   input logic [1:0] mm);
        logic [PTR_W-1:0] nv;
        logic [PTR_W-1:0] ad;
        nv = p;
        ad = p;
        unique case (cdec_mm_t'(mm))
            CDEC_MM_PREINC: begin
                nv = p + 16'h0001;
                ad = nv;
            end
            CDEC_MM_PREDEC: begin
                nv = p - 16'h0001;
                ad = nv;
            end
            CDEC_MM_POSTINC: nv = p + 16'h0001;
            CDEC_MM_POSTDEC: nv = p - 16'h0001;
        endcase
        mm_apply = {nv, ad};
    endfunction

    logic [PC_W-1:0] pc_inc;
    logic n_sel;
    logic [5:0] k6;
    logic [PTR_W-1:0] sel_ptr;
    logic [2*PTR_W-1:0] mm_res;
    logic [PTR_W-1:0] idx_addr;
    logic [PTR_W-1:0] ind_ptr;

    always_comb begin
        pc_inc = st_reg.pc + 15'h0001;
        n_sel = i_instr[N_SEL_BIT];
        k6 = i_instr[5:0];
        sel_ptr = st_reg.ptr[n_sel];
        // the 0nmm forms pick their pointer with bit 2, the k forms with bit 6
        ind_ptr = st_reg.ptr[i_instr[2]];
        mm_res = mm_apply(ind_ptr, i_instr[N_MM_BIT-1:0]);
        idx_addr = sel_ptr + {10'h000, k6};
    end

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.dev_reset = 1'b0;
        st_next.wdt_restart = 1'b0;
        st_next.mem_rd = 1'b0;
        st_next.mem_wr = 1'b0;
        stk.push = 1'b0;
        stk.pop = 1'b0;
        // return address is the word after the call
        stk.push_data = pc_inc;

        // wake comes from outside this clock: three flops, act once the last two agree
        st_next.wake_sync = {st_reg.wake_sync[1:0], i_wake};
        // a one-cycle wake pulse can be lost; wake must stand for two cycles or more
        if (st_reg.wake_sync[2] && st_reg.wake_sync[1]) begin
            st_next.sleep = 1'b0;
        end

        // read data is taken in the same cycle as the strobe; acc shows it one cycle later
        if (st_reg.ld_pending) begin
            st_next.acc = i_mem_rdata;
            st_next.zflag = (i_mem_rdata == 8'h00);
            st_next.ld_pending = 1'b0;
        end
        if (i_ext_wr_en) begin
            st_next.acc = i_ext_wdata;
        end
        unique case (st_reg.phase)
            CDEC_FLUSH: begin
                // the second cycle of a pc change runs as idle_op: nothing is taken
                st_next.phase = CDEC_EXEC;
            end
            CDEC_EXTRA: begin
                st_next.phase = CDEC_EXEC;
            end
            CDEC_LDWAIT: begin
                st_next.phase = CDEC_EXEC;
            end
            CDEC_EXEC: begin
                if (i_instr_valid && !st_reg.sleep) begin
                    st_next.pc = pc_inc;
                    // exact words first, since 0062-0064 also fit the direction pattern;
                    // unknown words fall through as idle_op but still advance the pc
                    if (i_instr == OP_IDLE) begin
                        st_next.pc = pc_inc;
                    end else if (i_instr == OP_SOFT_RESET) begin
                        st_next.dev_reset = 1'b1;
                        st_next.ri_n = 1'b0;
                    end else if (i_instr == OP_SUB_EXIT) begin
                        stk.pop = 1'b1;
                        st_next.pc = stk.top;
                        st_next.phase = CDEC_FLUSH;
                    end else if (i_instr == OP_IRQ_RETURN) begin
                        stk.pop = 1'b1;
                        st_next.pc = stk.top;
                        st_next.global_irq_enable = 1'b1;
                        st_next.phase = CDEC_FLUSH;
                    end else if (i_instr == OP_CALL_ACC) begin
                        stk.push = 1'b1;
                        st_next.pc = {st_reg.pc[PC_W-1:8], st_reg.acc};
                        st_next.phase = CDEC_FLUSH;
                    end else if (i_instr == OP_JREL_ACC) begin
                        st_next.pc = pc_inc + {7'h00, st_reg.acc};
                        st_next.phase = CDEC_FLUSH;
                    end else if (i_instr == OP_LOAD_PRESC) begin
                        st_next.presc = st_reg.acc;
                    end else if (i_instr == OP_SLEEP) begin
                        st_next.sleep = 1'b1;
                        st_next.to_flag = 1'b1;
                        st_next.pd_flag = 1'b0;
                        st_next.wdt_restart = 1'b1;
                    end else if (i_instr == OP_WDT_CLEAR) begin
                        st_next.wdt_restart = 1'b1;
                        st_next.to_flag = 1'b1;
                        st_next.pd_flag = 1'b1;
                    end else if (op_match(i_instr, MASK_DIR, PAT_DIR)) begin
                        st_next.dir[i_instr[2:0]] = st_reg.acc;
                    end else if (op_match(i_instr, MASK_LDI, PAT_LDI)
                                 || op_match(i_instr, MASK_LDI, PAT_STI)) begin
                        st_next.ptr[i_instr[2]] = mm_res[2*PTR_W-1:PTR_W];
                        st_next.mem_addr = mm_res[PTR_W-1:0];
                        if (i_instr[3]) begin
                            st_next.mem_wr = 1'b1;
                            st_next.mem_wdata = st_reg.acc;
                        end else begin
                            st_next.mem_rd = 1'b1;
                            st_next.ld_pending = 1'b1;
                        end
                        if (st_reg.ptr[i_instr[2]][PTR_W-1]) begin
                            st_next.phase = CDEC_EXTRA;
                        end
                    end else if (op_match(i_instr, MASK_K9, PAT_JREL)) begin
                        st_next.pc = pc_inc + PC_W'({{6{i_instr[8]}}, i_instr[8:0]});
                        st_next.phase = CDEC_FLUSH;
                    end else if (op_match(i_instr, MASK_K11, PAT_CALL)) begin
                        // upper pc bits are kept, so call and jump_abs stay in one 2K page
                        stk.push = 1'b1;
                        st_next.pc = {st_reg.pc[PC_W-1:11], i_instr[10:0]};
                        st_next.phase = CDEC_FLUSH;
                    end else if (op_match(i_instr, MASK_K11, PAT_JABS)) begin
                        st_next.pc = {st_reg.pc[PC_W-1:11], i_instr[10:0]};
                        st_next.phase = CDEC_FLUSH;
                    end else if (op_match(i_instr, MASK_K8, PAT_RETLIT)) begin
                        stk.pop = 1'b1;
                        st_next.acc = i_instr[7:0];
                        st_next.pc = stk.top;
                        st_next.phase = CDEC_FLUSH;
                    end else if (op_match(i_instr, MASK_K6, PAT_PADD)) begin
                        st_next.ptr[n_sel] = sel_ptr + {10'h000, k6};
                    end else if (op_match(i_instr, MASK_K6, PAT_LDX)
                                 || op_match(i_instr, MASK_K6, PAT_STX)) begin
                        st_next.mem_addr = idx_addr;
                        if (i_instr[7]) begin
                            st_next.mem_wr = 1'b1;
                            st_next.mem_wdata = st_reg.acc;
                        end else begin
                            st_next.mem_rd = 1'b1;
                            st_next.ld_pending = 1'b1;
                        end
                        if (sel_ptr[PTR_W-1]) begin
                            st_next.phase = CDEC_EXTRA;
                        end
                    end
                    // ld result is written next cycle; hold fetch so acc is settled
                    if (st_next.ld_pending && st_next.phase == CDEC_EXEC) begin
                        st_next.phase = CDEC_LDWAIT;
                    end
                end
            end
        endcase

        // stall is registered from the next state, so the fetch side loses no cycle
        st_next.stall = (st_next.phase != CDEC_EXEC) || st_next.sleep;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= '{
                phase: CDEC_EXEC,
                pc: PC_RESET,
                acc: 8'h00,
                zflag: 1'b0,
                global_irq_enable: 1'b0,
                to_flag: 1'b1,
                pd_flag: 1'b1,
                ri_n: 1'b1,
                dev_reset: 1'b0,
                wdt_restart: 1'b0,
                sleep: 1'b0,
                presc: PRESC_RESET,
                dir: {NUM_DIR{DIR_RESET}},
                ptr: {2{PTR_RESET}},
                mem_rd: 1'b0,
                mem_wr: 1'b0,
                mem_addr: PTR_RESET,
                mem_wdata: 8'h00,
                ld_pending: 1'b0,
                wake_sync: 3'h0,
                stall: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_program_counter = st_reg.pc;
    assign o_fetch_stall = st_reg.stall;
    assign o_accumulator = st_reg.acc;
    assign o_result_null_flag = st_reg.zflag;
    assign o_global_irq_enable = st_reg.global_irq_enable;
    assign o_watchdog_expiry_flag = st_reg.to_flag;
    assign o_powerdown_flag = st_reg.pd_flag;
    assign o_soft_reset_flag_n = st_reg.ri_n;
    assign o_device_reset = st_reg.dev_reset;
    assign o_watchdog_restart = st_reg.wdt_restart;
    assign o_sleep = st_reg.sleep;
    assign o_prescaler_config = st_reg.presc;
    assign o_direction = st_reg.dir;
    assign o_pointer0 = st_reg.ptr[0];
    assign o_pointer1 = st_reg.ptr[1];
    assign o_mem_rd = st_reg.mem_rd;
    assign o_mem_wr = st_reg.mem_wr;
    assign o_mem_addr = st_reg.mem_addr;
    assign o_mem_wdata = st_reg.mem_wdata;
endmodule // cdec_core
`default_nettype wire

// ### cdec_core_asserts.sv
// checker: timing and side-effect properties of the decoder top
`timescale 1ns/10ps
`default_nettype none
module cdec_core_asserts (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_ext_wr_en,
    input wire logic [cdec_pkg::PC_W-1:0] o_program_counter,
    input wire logic o_fetch_stall,
    input wire logic [7:0] o_accumulator,
    input wire logic o_result_null_flag,
    input wire logic o_global_irq_enable,
    input wire logic o_watchdog_expiry_flag,
    input wire logic o_powerdown_flag,
    input wire logic o_soft_reset_flag_n,
    input wire logic o_device_reset,
    input wire logic o_watchdog_restart,
    input wire logic o_sleep,
    input wire logic [7:0] o_prescaler_config,
    input wire logic [cdec_pkg::PTR_W-1:0] o_pointer0,
    input wire logic [cdec_pkg::PTR_W-1:0] o_pointer1,
    input wire logic o_mem_rd
);
    import cdec_pkg::*;
    logic tk;
    // an external accumulator write overrides a load result, so accumulator checks skip it
    logic ne;
    assign tk = i_instr_valid && !o_fetch_stall;
    assign ne = tk && !i_ext_wr_en;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_jrel;
        tk && (i_instr & MASK_K9) == PAT_JREL |=> o_fetch_stall && o_program_counter ==
            $past(o_program_counter) + 15'h0001 + {{6{$past(i_instr[8])}}, $past(i_instr[8:0])}
            ##1 !o_fetch_stall;
    endproperty
    a_jrel: assert property (p_jrel) else $error("jump_rel target or timing");
    property p_call;
        tk && (i_instr & MASK_K11) == PAT_CALL |=> o_fetch_stall &&
            o_program_counter[10:0] == $past(i_instr[10:0]);
    endproperty
    a_call: assert property (p_call) else $error("call target");
    property p_jabs;
        tk && (i_instr & MASK_K11) == PAT_JABS |=> o_fetch_stall &&
            o_program_counter[10:0] == $past(i_instr[10:0]);
    endproperty
    a_jabs: assert property (p_jabs) else $error("jump_abs target");
    property p_irqret;
        tk && i_instr == OP_IRQ_RETURN |=> o_global_irq_enable && o_fetch_stall ##1 !o_fetch_stall;
    endproperty
    a_irqret: assert property (p_irqret) else $error("irq_return effect");
    property p_retlit;
        ne && (i_instr & MASK_K8) == PAT_RETLIT |=> o_fetch_stall &&
            o_accumulator == $past(i_instr[7:0]);
    endproperty
    a_retlit: assert property (p_retlit) else $error("return_literal value");
    property p_wdt;
        tk && i_instr == OP_WDT_CLEAR |=> o_watchdog_restart && o_watchdog_expiry_flag &&
            o_powerdown_flag && !o_fetch_stall;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog_clear effect");
    property p_presc;
        tk && i_instr == OP_LOAD_PRESC |=> o_prescaler_config == $past(o_accumulator);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler load");
    property p_reset;
        tk && i_instr == OP_SOFT_RESET |=> o_device_reset && !o_soft_reset_flag_n;
    endproperty
    a_reset: assert property (p_reset) else $error("software reset effect");
    property p_sleep;
        tk && i_instr == OP_SLEEP |=> o_sleep && o_watchdog_expiry_flag && !o_powerdown_flag;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep effect");
    property p_load;
        ne && ((i_instr & MASK_LDI) == PAT_LDI || (i_instr & MASK_K6) == PAT_LDX) |=>
            o_mem_rd ##1 ($past(i_ext_wr_en) || (o_accumulator == $past(i_mem_rdata) &&
            o_result_null_flag == ($past(i_mem_rdata) == 8'h00)));
    endproperty
    a_load: assert property (p_load) else $error("indirect load result");
    property p_xstall;
        tk && (i_instr & MASK_K6) == PAT_STX && (i_instr[6] ? o_pointer1[15] : o_pointer0[15])
            |=> o_fetch_stall ##1 !o_fetch_stall;
    endproperty
    a_xstall: assert property (p_xstall) else $error("extra cycle missing");
endmodule // cdec_core_asserts
bind cdec_core cdec_core_asserts i_cdec_core_asserts (.i_clk, .i_rstn, .i_instr, .i_instr_valid,
    .i_mem_rdata, .i_ext_wr_en, .o_program_counter, .o_fetch_stall, .o_accumulator,
    .o_result_null_flag, .o_global_irq_enable, .o_watchdog_expiry_flag, .o_powerdown_flag,
    .o_soft_reset_flag_n, .o_device_reset, .o_watchdog_restart, .o_sleep, .o_prescaler_config,
    .o_pointer0, .o_pointer1, .o_mem_rd);
`default_nettype wire

// ### cdec_mem_model.sv
// partner model: program memory and data memory facing the decoder
`timescale 1ns/10ps
`default_nettype none
module cdec_mem_model (
    input wire logic i_clk,
    input wire logic [cdec_pkg::PC_W-1:0] i_pc,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [cdec_pkg::PTR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [13:0] o_instr,
    output logic [7:0] o_rdata
);
    import cdec_pkg::*;
    logic [13:0] rom [256];
    logic [7:0] ram [65536] = '{default: 8'h00};
    logic [7:0] last_q = 8'h00;
    assign o_instr = rom[i_pc[7:0]];
    // with no read selected, show the inverse of the last byte so stale data never matches
    assign o_rdata = i_rd ? ram[i_addr] : ~last_q;
    always @(posedge i_clk) begin
        if (i_wr) begin
            ram[i_addr] <= i_wdata;
        end
        if (i_rd) begin
            last_q <= ram[i_addr];
        end
    end
endmodule // cdec_mem_model
`default_nettype wire

// ### testbench.sv
// testbench: directed scenarios for the control and indirect-move decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
    import cdec_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_instr_valid = 1'b0;
    logic i_ext_wr_en = 1'b0;
    logic i_wake = 1'b0;
    logic [7:0] i_ext_wdata = 8'h00;
    logic [13:0] i_instr;
    logic [7:0] i_mem_rdata, o_accumulator, o_prescaler_config, o_mem_wdata;
    logic [PC_W-1:0] o_program_counter;
    logic o_fetch_stall, o_result_null_flag, o_global_irq_enable, o_watchdog_expiry_flag;
    logic o_powerdown_flag, o_soft_reset_flag_n, o_device_reset, o_watchdog_restart, o_sleep;
    logic o_mem_rd, o_mem_wr;
    logic [NUM_DIR*8-1:0] o_direction;
    logic [PTR_W-1:0] o_pointer0, o_pointer1, o_mem_addr;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 i_clk = ~i_clk;
    cdec_core i_cdec_core (.i_clk, .i_rstn, .i_instr, .i_instr_valid, .i_mem_rdata, .i_ext_wr_en,
        .i_ext_wdata, .i_wake, .o_program_counter, .o_fetch_stall, .o_accumulator,
        .o_result_null_flag, .o_global_irq_enable, .o_watchdog_expiry_flag, .o_powerdown_flag,
        .o_soft_reset_flag_n, .o_device_reset, .o_watchdog_restart, .o_sleep,
        .o_prescaler_config, .o_direction, .o_pointer0, .o_pointer1, .o_mem_rd, .o_mem_wr,
        .o_mem_addr, .o_mem_wdata);
    cdec_mem_model i_cdec_mem_model (.i_clk, .i_pc(o_program_counter), .i_rd(o_mem_rd),
        .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_instr(i_instr),
        .o_rdata(i_mem_rdata));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task prog(input logic [13:0] w [$]);
        for (int a = 0; a < 256; a++) begin
            i_cdec_mem_model.rom[a] = (a < w.size()) ? w[a] : OP_IDLE;
        end
    endtask
    // reset, preload the accumulator through the external port, then run
    task start(input logic [7:0] acc_v);
        i_rstn = 1'b0;
        i_instr_valid = 1'b0;
        cyc(2);
        i_rstn = 1'b1;
        i_ext_wr_en = 1'b1;
        i_ext_wdata = acc_v;
        cyc(1);
        i_ext_wr_en = 1'b0;
        i_instr_valid = 1'b1;
    endtask
    task finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset();
        prog('{OP_IDLE});
        `CHK("reset pc acc", {PC_RESET, 8'h00}, {o_program_counter, o_accumulator})
        `CHK("reset flags", 7'b0011100, {o_result_null_flag, o_global_irq_enable,
            o_watchdog_expiry_flag, o_powerdown_flag, o_soft_reset_flag_n, o_fetch_stall, o_sleep})
        `CHK("reset config", {PRESC_RESET, {NUM_DIR{DIR_RESET}}}, {o_prescaler_config, o_direction})
        `CHK("reset pointers", {PTR_RESET, PTR_RESET}, {o_pointer0, o_pointer1})
        i_rstn = 1'b1;
        i_instr_valid = 1'b1;
        cyc(3);
        `CHK("idle pc", 15'h0003, o_program_counter)
        `CHK("idle acc stall", 9'h000, {o_accumulator, o_fetch_stall})
        $display("test reset and idle done");
    endtask
    task t_flow();
        prog('{14'h3202, OP_IDLE, OP_IDLE, 14'h2007, 14'h200A, 14'h200B, 14'h33FF, 14'h2809,
            OP_IDLE, OP_SUB_EXIT, 14'h345A, OP_IRQ_RETURN});
        start(8'h00);
        cyc(16);
        `CHK("flow pc", 15'h0006, o_program_counter)
        `CHK("flow acc", 8'h5A, o_accumulator)
        `CHK("flow irq enable", 1'b1, o_global_irq_enable)
        cyc(1);
        `CHK("loop stall", 1'b1, o_fetch_stall)
        cyc(3);
        `CHK("loop pc", 15'h0006, o_program_counter)
        $display("test control flow done");
    endtask
    task t_acc_flow();
        prog('{OP_JREL_ACC, OP_IDLE, OP_IDLE, OP_IDLE, OP_IDLE, OP_SUB_EXIT, OP_CALL_ACC});
        start(8'h05);
        cyc(2);
        `CHK("branch by acc", 15'h0006, o_program_counter)
        cyc(4);
        `CHK("call by acc return", 15'h0007, o_program_counter)
        $display("test accumulator flow done");
    endtask
    task t_inherent();
        logic hit;
        hit = 1'b0;
        prog('{OP_LOAD_PRESC, 14'h0065, OP_WDT_CLEAR, OP_SLEEP, OP_WDT_CLEAR, OP_SOFT_RESET});
        start(8'h3C);
        cyc(3);
        `CHK("prescaler", 8'h3C, o_prescaler_config)
        `CHK("direction 5 and 0", 16'h3CFF, {o_direction[47:40], o_direction[7:0]})
        `CHK("watchdog clear", 3'b111, {o_watchdog_restart, o_watchdog_expiry_flag,
            o_powerdown_flag})
        cyc(1);
        `CHK("sleep flags", 3'b110, {o_sleep, o_watchdog_expiry_flag, o_powerdown_flag})
        cyc(3);
        `CHK("asleep pc", 15'h0004, o_program_counter)
        i_wake = 1'b1;
        for (int k = 0; k < 8 && !hit; k++) begin
            cyc(1);
            hit = (o_device_reset === 1'b1);
        end
        i_wake = 1'b0;
        `CHK("device reset pulse", 1'b1, hit)
        `CHK("powerdown after wake clear", 1'b1, o_powerdown_flag)
        `CHK("soft reset flag", 1'b0, o_soft_reset_flag_n)
        $display("test inherent done");
    endtask
    task t_indirect();
        prog('{14'h001F, 14'h3FC0, 14'h3110, 14'h001A, 14'h0011, 14'h3F21, 14'h0014});
        start(8'hA5);
        `CHK("flag restored", 1'b1, o_soft_reset_flag_n)
        cyc(1);
        `CHK("post-dec store", {1'b1, 16'h0000, 8'hA5, 16'hFFFF},
            {o_mem_wr, o_mem_addr, o_mem_wdata, o_pointer1})
        cyc(1);
        `CHK("window store extra", 1'b1, o_fetch_stall)
        cyc(3);
        `CHK("pointer add then store", {1'b1, 16'h0010, 16'h0011},
            {o_mem_wr, o_mem_addr, o_pointer0})
        cyc(2);
        `CHK("pre-dec load", {8'hA5, 1'b0, 16'h0010},
            {o_accumulator, o_result_null_flag, o_pointer0})
        cyc(2);
        `CHK("indexed load zero", {8'h00, 1'b1, 15'h0006},
            {o_accumulator, o_result_null_flag, o_program_counter})
        cyc(2);
        `CHK("pre-inc load via pointer 1", {8'hA5, 1'b0, 16'h0000, 15'h0007},
            {o_accumulator, o_result_null_flag, o_pointer1, o_program_counter})
        $display("test indirect done");
    endtask
    initial begin
        repeat (2000) @(posedge i_clk);
        fail_count++;
        $display("ERROR watchdog expected finish seen hang");
        finish_test();
    end
    initial begin
        cyc(10);
        t_reset();
        t_flow();
        t_acc_flow();
        t_inherent();
        t_indirect();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
